//--- rtl/epr_pkg.sv
// Constants for the external request pin block: register map and fields.
// Assumes a 32-bit APB slave with the control register in byte lane 0.
package epr_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] PIN_REQUEST_STATUS_CONTROL_OFFS = 12'h000;
   localparam logic [7:0] PIN_REQUEST_STATUS_CONTROL_RST = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int PULL_DEVICE_DISABLE_BIT = 6;
   localparam int EDGE_POLARITY_SELECT_BIT = 5;
   localparam int REQUEST_PIN_ENABLE_BIT = 4;
   localparam int REQUEST_EVENT_FLAG_BIT = 3;
   localparam int REQUEST_EVENT_ACKNOWLEDGE_BIT = 2;
   localparam int REQUEST_INTERRUPT_ENABLE_BIT = 1;
   localparam int DETECTION_MODE_SELECT_BIT = 0;

endpackage : epr_pkg

//--- rtl/epr_pin_detect.sv
// Event detector for the request pin: edge and edge-plus-level modes.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ps
module epr_pin_detect (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pin and controls
   input wire logic pin,
   input wire logic enable,
   input wire logic rising,
   input wire logic level_mode,
   // Results
   output logic asserted,
   output logic event_hit
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic prev_asserted;
   } epr_det_s;

   epr_det_s det_reg;
   epr_det_s det_next;

   always_comb begin
      // Polarity folded in, so one edge test serves both senses
      // polarity select
      asserted = rising ? pin : ~pin;
      det_next = det_reg;
      det_next.prev_asserted = asserted;
      event_hit = enable &
         ((asserted & ~det_reg.prev_asserted) | (level_mode & asserted));
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         det_reg <= '0;
      end else begin
         det_reg <= det_next;
      end
   end

endmodule : epr_pin_detect

//--- rtl/epr_top.sv
// External interrupt request pin logic with its APB control register.
// Assumes the pin is synchronous to the 40 MHz clock; pull device and
// CPU request are driven outward as plain levels.
//
// Notes on behaviour
// - Pull resistor off when pull-disable bit 6 set and pin enabled.
// - Bit 5 zero selects falling/low; one selects rising/high.
// - Rising polarity with pull enabled makes the pull a pulldown.
// - Pin-enable bit 4 low means the pin makes no events.
// - Read-only flag bit 3 sets on each qualifying pin event.
// - Writing one to bit 2 clears the flag; bit reads zero.
// - In level mode flag stays set while pin stays asserted.
// - Interrupt-enable bit 1 passes the flag as CPU request.
// - Mode bit 0: zero edges only, one edges and levels.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module epr_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [epr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request pin and pad control
   input wire logic request_pin,
   output logic pull_enable,
   output logic pull_down_select,
   // CPU request
   output logic cpu_irq
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic pull_device_disable;
      logic edge_polarity_select;
      logic request_pin_enable;
      logic request_interrupt_enable;
      logic detection_mode_select;
      logic request_event_flag;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic irq;
      logic pull_en;
      logic pull_dn;
   } epr_state_s;

   epr_state_s s_reg;
   epr_state_s s_next;

   logic asserted;
   logic event_hit;
   logic setup;
   logic hit;
   logic wr;
   logic ack;
   logic [7:0] rd_byte;

   // ****************************************
   // Detector
   // ****************************************
   epr_pin_detect u_detect (
      .clock(clock),
      .rst_n(rst_n),
      .pin(request_pin),
      .enable(s_reg.request_pin_enable),
      .rising(s_reg.edge_polarity_select),
      .level_mode(s_reg.detection_mode_select),
      .asserted(asserted),
      .event_hit(event_hit)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_next = s_reg;
      setup = psel & ~penable;
      hit = (paddr == epr_pkg::PIN_REQUEST_STATUS_CONTROL_OFFS);
      // Write lands only at the edge where the master sees pready
      wr = psel & penable & s_reg.ready & pwrite & hit & pstrb[0];
      ack = wr & pwdata[epr_pkg::REQUEST_EVENT_ACKNOWLEDGE_BIT];
      rd_byte = 8'h00;
      rd_byte[epr_pkg::PULL_DEVICE_DISABLE_BIT] = s_reg.pull_device_disable;
      rd_byte[epr_pkg::EDGE_POLARITY_SELECT_BIT] =
         s_reg.edge_polarity_select;
      rd_byte[epr_pkg::REQUEST_PIN_ENABLE_BIT] = s_reg.request_pin_enable;
      rd_byte[epr_pkg::REQUEST_EVENT_FLAG_BIT] = s_reg.request_event_flag;
      rd_byte[epr_pkg::REQUEST_INTERRUPT_ENABLE_BIT] =
         s_reg.request_interrupt_enable;
      rd_byte[epr_pkg::DETECTION_MODE_SELECT_BIT] =
         s_reg.detection_mode_select;
      // Zero wait state: answer is ready in the first access cycle
      s_next.ready = setup;
      s_next.slverr = setup & ~hit;
      if (setup) begin
         s_next.rdata = (hit & ~pwrite) ? {24'h000000, rd_byte} : 32'h0;
      end
      if (wr) begin
         s_next.pull_device_disable =
            pwdata[epr_pkg::PULL_DEVICE_DISABLE_BIT];
         s_next.edge_polarity_select =
            pwdata[epr_pkg::EDGE_POLARITY_SELECT_BIT];
         s_next.request_pin_enable = pwdata[epr_pkg::REQUEST_PIN_ENABLE_BIT];
         s_next.request_interrupt_enable =
            pwdata[epr_pkg::REQUEST_INTERRUPT_ENABLE_BIT];
         s_next.detection_mode_select =
            pwdata[epr_pkg::DETECTION_MODE_SELECT_BIT];
      end
      if (event_hit) begin
         s_next.request_event_flag = 1'b1;
      end else if (ack) begin
         s_next.request_event_flag = 1'b0;
      end
      s_next.irq = s_next.request_interrupt_enable &
         s_next.request_event_flag;
      s_next.pull_en = s_next.request_pin_enable &
         ~s_next.pull_device_disable;
      s_next.pull_dn = s_next.pull_en & s_next.edge_polarity_select;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.rdata;
   assign pready = s_reg.ready;
   assign pslverr = s_reg.slverr;
   assign pull_enable = s_reg.pull_en;
   assign pull_down_select = s_reg.pull_dn;
   assign cpu_irq = s_reg.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   logic wr_pe_pdd;
   logic wr_pull_rise;
   assign wr_pe_pdd = wr & pwdata[epr_pkg::REQUEST_PIN_ENABLE_BIT] &
      pwdata[epr_pkg::PULL_DEVICE_DISABLE_BIT];
   assign wr_pull_rise = wr & pwdata[epr_pkg::REQUEST_PIN_ENABLE_BIT] &
      ~pwdata[epr_pkg::PULL_DEVICE_DISABLE_BIT] &
      pwdata[epr_pkg::EDGE_POLARITY_SELECT_BIT];

   a_pull_off_write: assert property (
      wr_pe_pdd |=> !pull_enable ##0 !pull_down_select)
      else $error("pull device still on after disable write");

   a_pull_down_select: assert property (
      wr_pull_rise |=> pull_enable && pull_down_select)
      else $error("pulldown not selected for rising polarity");

   a_rise_sets_flag: assert property (
      s_reg.request_pin_enable && s_reg.edge_polarity_select &&
      $past(s_reg.edge_polarity_select) && $rose(request_pin)
      |=> s_reg.request_event_flag)
      else $error("rising edge did not set flag");

   a_fall_sets_flag: assert property (
      s_reg.request_pin_enable && !s_reg.edge_polarity_select &&
      $past(!s_reg.edge_polarity_select) && $fell(request_pin)
      |=> s_reg.request_event_flag)
      else $error("falling edge did not set flag");

   a_disabled_quiet: assert property (
      !s_reg.request_pin_enable && !s_reg.request_event_flag
      |=> !s_reg.request_event_flag)
      else $error("flag set while pin disabled");

   a_ack_clears_flag: assert property (
      ack && !event_hit |=> !s_reg.request_event_flag)
      else $error("acknowledge did not clear flag");

   a_ack_reads_zero: assert property (
      pready |-> !prdata[epr_pkg::REQUEST_EVENT_ACKNOWLEDGE_BIT])
      else $error("acknowledge bit read back as one");

   a_level_holds_flag: assert property (
      s_reg.request_pin_enable && s_reg.detection_mode_select && asserted
      |=> s_reg.request_event_flag [*1] ##1 1'b1)
      else $error("flag cleared while level asserted");

   a_irq_gate: assert property (
      $rose(s_reg.request_event_flag) && s_reg.request_interrupt_enable &&
      $past(s_reg.request_interrupt_enable) |-> cpu_irq)
      else $error("request not raised with enable and flag");

   a_irq_masked: assert property (
      !s_reg.request_interrupt_enable |-> !cpu_irq)
      else $error("request raised while masked");

   a_edge_only: assert property (
      s_reg.request_pin_enable && !s_reg.detection_mode_select &&
      asserted && $past(asserted) && $stable(s_reg.edge_polarity_select) &&
      $past(s_reg.request_pin_enable) && !s_reg.request_event_flag
      |=> !s_reg.request_event_flag)
      else $error("steady level set flag in edge mode");

   a_reset_clears: assert property (
      @(posedge clock) disable iff (1'b0)
      !rst_n |=> !s_reg.request_event_flag && !s_reg.request_pin_enable &&
      !s_reg.request_interrupt_enable && !cpu_irq && !pull_enable)
      else $error("state not cleared by reset");

   // ****************************************
   // Pad, flag and request checks
   // ****************************************
   a_pull_on_enabled: assert property (
      s_reg.request_pin_enable && !s_reg.pull_device_disable
      |-> pull_enable)
      else $error("pull device off while enabled");

   a_pull_off_idle: assert property (
      !s_reg.request_pin_enable |-> !pull_enable)
      else $error("pull device on while pin disabled");

   a_pullup_falling: assert property (
      pull_enable && !s_reg.edge_polarity_select |-> !pull_down_select)
      else $error("pulldown selected for falling polarity");

   a_pulldown_gated: assert property (
      pull_down_select |-> pull_enable)
      else $error("pulldown selected with pull device off");

   a_fall_ignored: assert property (
      s_reg.request_pin_enable && !s_reg.detection_mode_select &&
      s_reg.edge_polarity_select && $stable(s_reg.edge_polarity_select) &&
      $fell(request_pin) && !s_reg.request_event_flag
      |=> !s_reg.request_event_flag)
      else $error("falling edge set flag with rising polarity");

   a_flag_needs_event: assert property (
      $rose(s_reg.request_event_flag) |-> $past(event_hit))
      else $error("flag set with no pin event");

   a_ack_zero_keeps: assert property (
      wr && !pwdata[epr_pkg::REQUEST_EVENT_ACKNOWLEDGE_BIT] &&
      s_reg.request_event_flag |=> s_reg.request_event_flag)
      else $error("flag cleared by a zero acknowledge");

   a_set_beats_ack: assert property (
      ack && event_hit |=> s_reg.request_event_flag)
      else $error("acknowledge won over a pin event");

   a_level_mode_set: assert property (
      s_reg.request_pin_enable && s_reg.detection_mode_select &&
      asserted && !s_reg.request_event_flag |=> s_reg.request_event_flag)
      else $error("asserted level did not set flag");

   a_irq_follows_flag: assert property (
      s_reg.request_interrupt_enable && s_reg.request_event_flag
      |-> cpu_irq)
      else $error("request missing with enable and flag");

   a_irq_needs_flag: assert property (
      cpu_irq |-> s_reg.request_event_flag)
      else $error("request raised with flag clear");

   // ****************************************
   // Bus checks and cover points
   // ****************************************
   // Zero wait state slave, so ready is a single pulse
   a_ready_one_cycle: assert property (
      pready |=> !pready)
      else $error("ready held beyond one cycle");

   a_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error response without ready");

   a_upper_bits_zero: assert property (
      pready |-> prdata[31:7] == 25'h0)
      else $error("unused read bits not zero");

   c_edge_event: cover property (
      !s_reg.detection_mode_select && event_hit);
   c_level_hold: cover property (
      ack && event_hit && s_reg.detection_mode_select);
   c_ack_clear: cover property (ack ##1 !s_reg.request_event_flag);
   c_irq_raise: cover property ($rose(cpu_irq));
   c_pull_down: cover property ($rose(pull_down_select));

endmodule : epr_top

//--- tb/epr_pin_model.sv
// External device on the request pin, with the pad's pull device.
// Assumes the bench chooses when the device drives and at what level.
`timescale 1ns/1ps
module epr_pin_model (
   // Clock
   input wire logic clock,
   // Bench control
   input wire logic drive_en,
   input wire logic drive_val,
   // Pad control from the block
   input wire logic pull_enable,
   input wire logic pull_down_select,
   // Pin
   output logic request_pin
);
   // Undriven, unpulled pin wanders, never a settled value
   logic float_reg;
   always_ff @(posedge clock) begin
      float_reg <= ~request_pin;
   end
   assign request_pin = drive_en ? drive_val :
      (pull_enable ? ~pull_down_select : float_reg);
endmodule : epr_pin_model

//--- tb/epr_top_test.sv
// Self-checking bench: APB register accesses and pin stimulus.
// Assumes zero or more wait states; waits for pready, bounded by watchdog.
`timescale 1ns/1ps
module epr_top_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [epr_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, request_pin, pull_enable, pull_down_select;
   logic cpu_irq;
   logic drive_en = 1'b1;
   logic drive_val = 1'b1;
   logic [31:0] rd_data;
   logic rd_err;
   int miscompares = 0;
   int num_checks = 0;

   epr_top dut (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .request_pin(request_pin), .pull_enable(pull_enable),
      .pull_down_select(pull_down_select), .cpu_irq(cpu_irq));
   epr_pin_model pin_dev (.clock(clock), .drive_en(drive_en),
      .drive_val(drive_val), .pull_enable(pull_enable),
      .pull_down_select(pull_down_select), .request_pin(request_pin));

   initial begin
      forever #12.5 clock = ~clock;
   end

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic apb(input logic is_wr,
                      input logic [epr_pkg::ADDR_W-1:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      // Sampled at the edge, before that edge updates the slave
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic wr(input logic [7:0] d);
      apb(1'b1, epr_pkg::PIN_REQUEST_STATUS_CONTROL_OFFS, {24'h000000, d},
         4'hF);
   endtask : wr
   task automatic rd(input logic [7:0] exp);
      apb(1'b0, epr_pkg::PIN_REQUEST_STATUS_CONTROL_OFFS, 32'h00000000,
         4'h0);
      chk_word(rd_data, {24'h000000, exp});
   endtask : rd
   task automatic pin(input logic v);
      @(posedge clock);
      drive_val <= v;
      repeat (2) @(posedge clock);
      #1;
   endtask : pin
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // Generous span, tests take about 140 cycles
   initial begin
      #100us;
      miscompares++;
      final_report();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rd(8'h00);
      chk_bit(cpu_irq, 1'b0);
      chk_bit(pull_enable, 1'b0);
      apb(1'b0, 12'h004, 32'h00000000, 4'h0);
      chk_bit(rd_err, 1'b1);
      $display("test reset_and_map done");
      wr(8'h10);
      @(posedge clock);
      drive_en <= 1'b0;
      #1;
      chk_bit(pull_enable, 1'b1);
      chk_bit(request_pin, 1'b1);
      wr(8'h30);
      chk_bit(pull_down_select, 1'b1);
      chk_bit(request_pin, 1'b0);
      wr(8'h70);
      chk_bit(pull_enable, 1'b0);
      @(posedge clock);
      drive_en <= 1'b1;
      wr(8'h04);
      wr(8'h04);
      rd(8'h00);
      $display("test pull_device done");
      wr(8'h12);
      rd(8'h12);
      pin(1'b0);
      chk_bit(cpu_irq, 1'b1);
      rd(8'h1A);
      wr(8'h12);
      rd(8'h1A);
      wr(8'h16);
      rd(8'h12);
      chk_bit(cpu_irq, 1'b0);
      $display("test falling_edge done");
      wr(8'h13);
      wr(8'h17);
      rd(8'h1B);
      pin(1'b1);
      wr(8'h17);
      rd(8'h13);
      wr(8'h11);
      pin(1'b0);
      rd(8'h19);
      chk_bit(cpu_irq, 1'b0);
      pin(1'b1);
      wr(8'h15);
      rd(8'h11);
      $display("test level_mode done");
      wr(8'h32);
      wr(8'h36);
      rd(8'h32);
      pin(1'b0);
      rd(8'h32);
      pin(1'b1);
      rd(8'h3A);
      chk_bit(cpu_irq, 1'b1);
      $display("test rising_edge done");
      wr(8'h06);
      pin(1'b0);
      pin(1'b1);
      rd(8'h02);
      chk_bit(cpu_irq, 1'b0);
      apb(1'b1, 12'h004, 32'h00000010, 4'hF);
      chk_bit(rd_err, 1'b1);
      rd(8'h02);
      apb(1'b1, epr_pkg::PIN_REQUEST_STATUS_CONTROL_OFFS, 32'h00000010,
         4'h0);
      chk_bit(rd_err, 1'b0);
      rd(8'h02);
      $display("test pin_disabled done");
      final_report();
   end
endmodule : epr_top_test
